//--- wdog_pkg.sv
package wdog_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'hC;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int ACTIVATE_POS = 7;
   localparam int TOP_POS = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h7F;
   localparam logic [6:0] COUNT_TRIP = 7'h40;

   // Events: bit 0 timeout reset, bit 1 forced software reset
   localparam int EVT_W = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int PRESCALE_W = 16;
   localparam int RST_PULSE_NS = 500;
   localparam int RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;
   localparam int WAKE_DELAY_CYC = 514;

   typedef struct packed {
      logic activate;
      logic [6:0] count;
   } control_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_HALT = 2'b01,
      ST_WAKE = 2'b10
   } power_state_t;

endpackage

//--- windowed_countdown_watchdog.sv
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none

module windowed_countdown_watchdog
   import wdog_pkg::*;
#(
   parameter int WAKE_CYC = WAKE_DELAY_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic hw_variant_i,
   input wire logic wait_mode_i,
   input wire logic halt_mode_i,
   input wire logic ext_wake_i,
   input wire logic [3:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   output logic chip_reset_n_o,
   output logic irq_o
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [1:0] hw_sync_q;
   logic [1:0] halt_sync_q;
   logic [1:0] wake_sync_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hw_sync_q <= 2'h0;
         halt_sync_q <= 2'h0;
         wake_sync_q <= 2'h0;
      end else begin
         hw_sync_q <= {hw_sync_q[0], hw_variant_i};
         halt_sync_q <= {halt_sync_q[0], halt_mode_i};
         wake_sync_q <= {wake_sync_q[0], ext_wake_i};
      end
   end

   logic hw_variant;
   logic halt_req;
   logic wake_req;
   assign hw_variant = hw_sync_q[1];
   assign halt_req = halt_sync_q[1];
   assign wake_req = wake_sync_q[1];

   // Wait mode deliberately unused: watchdog behaves as in run
   logic unused_wait;
   assign unused_wait = wait_mode_i;

   // ----------------------------------------------------------------
   // Halt and wake sequencing
   // ----------------------------------------------------------------
   power_state_t pwr_q;
   logic [9:0] wake_cnt_q;
   logic running;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr_q <= ST_RUN;
         wake_cnt_q <= 10'h000;
      end else begin
         case (pwr_q)
            ST_RUN: begin
               if (halt_req) begin
                  pwr_q <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (wake_req) begin
                  pwr_q <= ST_WAKE;
                  wake_cnt_q <= 10'h000;
               end
            end
            ST_WAKE: begin
               if (wake_cnt_q == 10'(WAKE_CYC - 1)) begin
                  pwr_q <= ST_RUN;
               end else begin
                  wake_cnt_q <= wake_cnt_q + 10'h001;
               end
            end
            default: begin
               pwr_q <= ST_RUN;
            end
         endcase
      end
   end

   assign running = (pwr_q == ST_RUN);

   // ----------------------------------------------------------------
   // Prescaler and countdown
   // ----------------------------------------------------------------
   logic [PRESCALE_W-1:0] pre_q;
   logic tick;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_q <= '0;
      end else if (running) begin
         pre_q <= pre_q + 1'b1;
      end
   end

   assign tick = running && (pre_q == {PRESCALE_W{1'b1}});

   // Bus strobes
   logic req;
   logic ack_q;
   logic wr_ctl;
   logic wr_irq_clr;
   logic wr_irq_en;
   assign req = cyc_i && stb_i && !ack_q;
   assign wr_ctl = req && we_i && sel_i[0] && (adr_i == ADDR_CONTROL);
   assign wr_irq_clr = req && we_i && sel_i[0] && (adr_i == ADDR_IRQ_STATUS);
   assign wr_irq_en = req && we_i && sel_i[0] && (adr_i == ADDR_IRQ_ENABLE);

   control_t ctl_q;
   logic active;
   logic trip;
   logic force_rst;

   assign active = hw_variant || ctl_q.activate;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctl_q <= CONTROL_RESET;
      end else if (wr_ctl) begin
         // Activate bit can only be set, never cleared by software
         ctl_q.activate <= ctl_q.activate | dat_i[ACTIVATE_POS];
         ctl_q.count <= dat_i[TOP_POS:0];
      end else if (tick) begin
         ctl_q.count <= ctl_q.count - 7'h01;
      end
   end

   // Timeout: only decrement from 40h clears the top bit
   assign trip = running && tick && active &&
                 (ctl_q.count == COUNT_TRIP);
   // Forced reset: effective activate with top bit written zero
   assign force_rst = wr_ctl && !dat_i[TOP_POS] &&
                      (hw_variant || ctl_q.activate ||
                       dat_i[ACTIVATE_POS]);

   // ----------------------------------------------------------------
   // Reset pulse
   // ----------------------------------------------------------------
   // Pulse counter survives rst_i so the pin stays low its full width
   logic [7:0] pulse_q = 8'h00;

   always_ff @(posedge clk_i) begin
      if (trip || force_rst) begin
         pulse_q <= 8'(RST_PULSE_CYC);
      end else if (pulse_q != 8'h00) begin
         pulse_q <= pulse_q - 8'h01;
      end
   end

   assign chip_reset_n_o = (pulse_q == 8'h00);

   // Cause flag is kept across rst_i so software sees it afterwards
   logic wd_flag_q = 1'b0;

   always_ff @(posedge clk_i) begin
      if (trip || force_rst) begin
         wd_flag_q <= 1'b1;
      end else if (req && !we_i && (adr_i == ADDR_STATUS)) begin
         wd_flag_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   logic [EVT_W-1:0] irq_stat_q;
   logic [EVT_W-1:0] irq_en_q;
   logic [EVT_W-1:0] evt;
   assign evt = {force_rst, trip};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_q <= '0;
      end else begin
         // Set wins over clear
         irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? dat_i[EVT_W-1:0] :
                       {EVT_W{1'b0}})) | evt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en_q <= '0;
      end else if (wr_irq_en) begin
         irq_en_q <= dat_i[EVT_W-1:0];
      end
   end

   assign irq_o = |(irq_stat_q & irq_en_q);

   // ----------------------------------------------------------------
   // Wishbone slave, one-cycle ack registered after one wait state
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_q <= cyc_i && stb_i && !ack_q;
         dat_o <= 32'h0000_0000;
         if (req && !we_i) begin
            if (adr_i == ADDR_CONTROL) begin
               dat_o <= {24'h00_0000, ctl_q};
            end else if (adr_i == ADDR_STATUS) begin
               dat_o <= {29'h0, hw_variant, active, wd_flag_q};
            end else if (adr_i == ADDR_IRQ_STATUS) begin
               dat_o <= {30'h0, irq_stat_q};
            end else if (adr_i == ADDR_IRQ_ENABLE) begin
               dat_o <= {30'h0, irq_en_q};
            end else begin
               dat_o <= 32'h0000_0000;
            end
         end
      end
   end

   assign ack_o = ack_q;

   // ----------------------------------------------------------------
   // Check helpers
   // ----------------------------------------------------------------
   // Running cycles since the last tick, independent of the prescaler
   logic [PRESCALE_W:0] gap_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_q <= '0;
      end else if (tick) begin
         gap_q <= '0;
      end else if (running) begin
         gap_q <= gap_q + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_DECREMENT: assert property (@(posedge clk_i) disable iff (rst_i)
      tick && !wr_ctl |=> ctl_q.count == $past(ctl_q.count) - 7'h01)
      else $error("count did not decrement on tick");
   AST_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
      running && tick && active && ctl_q.count == 7'h40 && !wr_ctl
      |=> !chip_reset_n_o) else $error("no reset on timeout");
   AST_PULSE: assert property (@(posedge clk_i)
      $rose(pulse_q == 8'(RST_PULSE_CYC)) |-> ##49 !chip_reset_n_o ##1
      chip_reset_n_o) else $error("reset pulse width wrong");
   AST_NO_TRIP_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
      !active && !wr_ctl |-> !trip) else $error("reset while idle");
   AST_ACT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      ctl_q.activate |=> ctl_q.activate)
      else $error("activate bit cleared");
   AST_FORCE: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_ctl && dat_i[ACTIVATE_POS] && !dat_i[TOP_POS] |=> wd_flag_q &&
      !chip_reset_n_o) else $error("forced reset missing");
   AST_HALT_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
      !running && !wr_ctl |=> $stable(ctl_q.count))
      else $error("count moved in halt");
   AST_HW_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
      hw_variant |-> active) else $error("hardware variant inactive");
   AST_RESET_VAL: assert property (@(posedge clk_i)
      rst_i |=> ctl_q == 8'h7F) else $error("bad control reset");

   // ----------------------------------------------------------------
   // Further checks
   // ----------------------------------------------------------------
   AST_TICK_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
      tick |-> gap_q == {1'b0, {PRESCALE_W{1'b1}}})
      else $error("tick period wrong");
   AST_TICK_DUE: assert property (@(posedge clk_i) disable iff (rst_i)
      running && gap_q == {1'b0, {PRESCALE_W{1'b1}}} |-> tick)
      else $error("tick missing");
   AST_COUNT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      !tick && !wr_ctl |=> $stable(ctl_q.count))
      else $error("count moved without tick");
   AST_SW_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> !ctl_q.activate)
      else $error("active after reset");
   AST_PULSE_STEP: assert property (@(posedge clk_i)
      pulse_q != 8'h00 && !trip && !force_rst |=> pulse_q ==
      $past(pulse_q) - 8'h01) else $error("pulse count skipped");
   AST_FORCE_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
      force_rst |=> pulse_q == 8'(RST_PULSE_CYC))
      else $error("forced pulse not loaded");
   AST_TRIP_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      trip |=> irq_stat_q[0])
      else $error("timeout status missing");
   AST_FORCE_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
      force_rst |=> irq_stat_q[1])
      else $error("forced status missing");
   AST_IRQ_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      irq_stat_q[0] && !(wr_irq_clr && dat_i[0]) |=> irq_stat_q[0])
      else $error("status bit lost");
   AST_FLAG_KEEP: assert property (@(posedge clk_i)
      wd_flag_q && !(req && !we_i && adr_i == ADDR_STATUS) |=> wd_flag_q)
      else $error("cause flag lost");
   AST_HALT_NO_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
      !running |-> !trip)
      else $error("timeout while halted");
   AST_WAKE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
      pwr_q == ST_WAKE && wake_cnt_q != 10'(WAKE_CYC - 1) |=> !running)
      else $error("wake delay too short");
   AST_WAKE_END: assert property (@(posedge clk_i) disable iff (rst_i)
      pwr_q == ST_WAKE && wake_cnt_q == 10'(WAKE_CYC - 1) |=> running)
      else $error("wake delay too long");
   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing");

   COV_TRIP: cover property (@(posedge clk_i) trip);
   COV_FORCE: cover property (@(posedge clk_i) force_rst);
   COV_WAKE: cover property (@(posedge clk_i) pwr_q == ST_WAKE);
   COV_IRQ: cover property (@(posedge clk_i) irq_o);
   COV_HALT: cover property (@(posedge clk_i) pwr_q == ST_HALT);

endmodule // windowed_countdown_watchdog
`default_nettype wire

//--- windowed_countdown_watchdog_tb.sv
`timescale 1ns/100ps
`default_nettype none

module windowed_countdown_watchdog_tb;
   import wdog_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hw_variant_i = 1'b0;
   logic wait_mode_i = 1'b0;
   logic halt_mode_i = 1'b0;
   logic ext_wake_i = 1'b0;
   time t0;
   logic [3:0] adr_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic ack_o;
   logic chip_reset_n_o;
   logic irq_o;
   int err_count = 0;
   int n_compared = 0;
   int seed = 39;
   int n;
   logic [31:0] rd;
   logic [7:0] exp_ctrl;

   windowed_countdown_watchdog #(.WAKE_CYC(4)) i_dut (.clk_i(clk_i),
      .rst_i(rst_i), .hw_variant_i(hw_variant_i), .wait_mode_i(wait_mode_i),
      .halt_mode_i(halt_mode_i), .ext_wake_i(ext_wake_i), .adr_i(adr_i),
      .dat_i(dat_i),
      .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .ack_o(ack_o), .chip_reset_n_o(chip_reset_n_o),
      .irq_o(irq_o));

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // Wait mode toggles at random; counting must not notice
   always @(posedge clk_i) begin
      wait_mode_i <= 1'($random(seed));
   end

   // ---------------------------------------------
   // Compare, bus and closing tasks
   // ---------------------------------------------
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_reg({31'h0, got}, {31'h0, exp});
   endtask

   task automatic close_out();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [31:0] q);
      int k;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h0, d};
      sel_i <= 4'hF;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (k >= 20) begin
         err_count++;
         close_out();
      end
   endtask

   // Waits for the reset pin to fall, then measures its low time
   task automatic pulse(input int lim);
      n = 0;
      while (chip_reset_n_o !== 1'b0 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim) begin
         err_count++;
         close_out();
      end
      n = 0;
      while (chip_reset_n_o === 1'b0 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      check_reg(n, RST_PULSE_CYC);
   endtask

   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      // Option pin needs two edges through its synchroniser
      repeat (2) @(posedge clk_i);
   endtask

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, ADDR_CONTROL, 8'h00, rd);
      check_reg(rd, {24'h0, CONTROL_RESET});
      wb(1'b0, ADDR_STATUS, 8'h00, rd);
      check_reg(rd, 32'h0);
      wb(1'b0, 4'h2, 8'h00, rd);
      check_reg(rd, 32'h0);
      wb(1'b1, ADDR_IRQ_ENABLE, 8'h03, rd);
      $display("Reset values test done");
      exp_ctrl = 8'hC0 | 8'($random(seed) & 63);
      wb(1'b1, ADDR_CONTROL, exp_ctrl, rd);
      wb(1'b0, ADDR_CONTROL, 8'h00, rd);
      check_reg(rd, {24'h0, exp_ctrl});
      wb(1'b1, ADDR_CONTROL, 8'h45, rd);
      wb(1'b0, ADDR_CONTROL, 8'h00, rd);
      check_reg(rd, 32'hC5);
      check_bit(chip_reset_n_o, 1'b1);
      $display("Refresh test done");
      wb(1'b1, ADDR_CONTROL, 8'h80, rd);
      pulse(5);
      check_bit(irq_o, 1'b1);
      wb(1'b0, ADDR_IRQ_STATUS, 8'h00, rd);
      check_reg(rd, 32'h2);
      wb(1'b1, ADDR_IRQ_STATUS, 8'h02, rd);
      check_bit(irq_o, 1'b0);
      do_reset();
      wb(1'b0, ADDR_STATUS, 8'h00, rd);
      check_reg(rd, 32'h1);
      wb(1'b0, ADDR_STATUS, 8'h00, rd);
      check_reg(rd, 32'h0);
      wb(1'b0, ADDR_CONTROL, 8'h00, rd);
      check_reg(rd, {24'h0, CONTROL_RESET});
      $display("Forced reset test done");
      t0 = $time;
      wb(1'b1, ADDR_IRQ_ENABLE, 8'h03, rd);
      wb(1'b1, ADDR_CONTROL, 8'hC0, rd);
      halt_mode_i <= 1'b1;
      repeat (300) @(posedge clk_i);
      wb(1'b0, ADDR_CONTROL, 8'h00, rd);
      check_reg(rd, 32'hC0);
      halt_mode_i <= 1'b0;
      ext_wake_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_wake_i <= 1'b0;
      pulse(66000);
      // 65536 running cycles plus about 307 frozen, plus the pulse
      check_bit(((($time - t0) / 10) >= 65870) &&
                ((($time - t0) / 10) <= 65910), 1'b1);
      wb(1'b0, ADDR_CONTROL, 8'h00, rd);
      check_reg(rd, 32'hBF);
      wb(1'b0, ADDR_IRQ_STATUS, 8'h00, rd);
      check_reg(rd, 32'h1);
      $display("Timeout test done");
      hw_variant_i <= 1'b1;
      do_reset();
      wb(1'b1, ADDR_CONTROL, 8'h00, rd);
      pulse(5);
      wb(1'b0, ADDR_STATUS, 8'h00, rd);
      check_reg(rd & 32'h5, 32'h5);
      $display("Hardware variant test done");
      close_out();
   end
endmodule // windowed_countdown_watchdog_tb

`default_nettype wire
